// file: logic/wsd_cfg.svh
// field positions and encodings for the wide store / alu / shift decoder
`ifndef WSD_CFG_SVH
`define WSD_CFG_SVH
`define WSD_STORE_MATCH 9'h1f0
`define WSD_DP_MATCH 7'h75
`define WSD_SEL_BYTE_IMM 3'h4
`define WSD_SEL_HALF_IMM 3'h5
`define WSD_SEL_WORD_IMM 3'h6
`define WSD_SEL_BYTE 3'h0
`define WSD_SEL_HALF 3'h1
`define WSD_SEL_WORD 3'h2
`define WSD_FN_AND 4'h0
`define WSD_FN_BITCLR 4'h1
`define WSD_FN_OR 4'h2
`define WSD_FN_ORNOT 4'h3
`define WSD_FN_XOR 4'h4
`define WSD_FN_ADD 4'h8
`define WSD_FN_ADC 4'ha
`define WSD_FN_SUBC 4'hb
`define WSD_FN_SUB 4'hd
`define WSD_FN_RSUB 4'he
`define WSD_REG_PC 4'hf
`define WSD_SH_LEFT 2'h0
`define WSD_SH_RIGHT 2'h1
`define WSD_SH_ARITH 2'h2
`define WSD_SH_ROT 2'h3
`define WSD_AMT_ZERO 5'h00
`endif

// file: logic/wsd_pkg.sv
// operation type shared by the decoder and its shift sub-decoder
`default_nettype none
package wsd_pkg;
  typedef enum logic [4:0] {
    WSD_OP_NONE = 5'h00,
    WSD_OP_BYTE_STORE_IMM = 5'h01,
    WSD_OP_BYTE_STORE_REG = 5'h02,
    WSD_OP_HALFWORD_STORE_IMM = 5'h03,
    WSD_OP_HALFWORD_STORE_REG = 5'h04,
    WSD_OP_WORD_STORE_IMM = 5'h05,
    WSD_OP_WORD_STORE_REG = 5'h06,
    WSD_OP_AND = 5'h07,
    WSD_OP_TEST_BITS = 5'h08,
    WSD_OP_BIT_CLEAR = 5'h09,
    WSD_OP_BITWISE_OR = 5'h0a,
    WSD_OP_OR_NOT = 5'h0b,
    WSD_OP_BITWISE_NOT = 5'h0c,
    WSD_OP_EXCLUSIVE_OR = 5'h0d,
    WSD_OP_TEST_EQUIVALENCE = 5'h0e,
    WSD_OP_ADD = 5'h0f,
    WSD_OP_COMPARE_NEGATIVE = 5'h10,
    WSD_OP_ADD_WITH_CARRY = 5'h11,
    WSD_OP_SUBTRACT_WITH_BORROW = 5'h12,
    WSD_OP_SUBTRACT = 5'h13,
    WSD_OP_COMPARE = 5'h14,
    WSD_OP_REVERSE_SUBTRACT = 5'h15,
    WSD_OP_MOVE = 5'h16,
    WSD_OP_SHIFT_LEFT_LOGICAL = 5'h17,
    WSD_OP_SHIFT_RIGHT_LOGICAL = 5'h18,
    WSD_OP_SHIFT_RIGHT_ARITH = 5'h19,
    WSD_OP_ROTATE_EXTEND = 5'h1a,
    WSD_OP_ROTATE_RIGHT = 5'h1b
  } wsd_op_t;
endpackage : wsd_pkg
`default_nettype wire

// file: logic/wsd_shift_dec.sv
// move and immediate shift sub-decoder
`timescale 1ns/10ps
`default_nettype none
`include "wsd_cfg.svh"
module wsd_shift_dec (
  // second halfword
  input wire logic [15:0] hw2,
  // decoded shift
  output var wsd_pkg::wsd_op_t shift_op,
  output logic [4:0] shift_amt
);
  logic [1:0] shift_type;

  always_comb
  begin
    shift_amt = {hw2[14:12], hw2[7:6]}; // RULE19
    shift_type = hw2[5:4]; // RULE19
    shift_op = wsd_pkg::WSD_OP_MOVE;
    unique case (shift_type)
      `WSD_SH_LEFT:
      begin
        if (shift_amt == `WSD_AMT_ZERO)
          shift_op = wsd_pkg::WSD_OP_MOVE; // RULE15
        else
          shift_op = wsd_pkg::WSD_OP_SHIFT_LEFT_LOGICAL; // RULE15
      end
      `WSD_SH_RIGHT: shift_op = wsd_pkg::WSD_OP_SHIFT_RIGHT_LOGICAL; // RULE16
      `WSD_SH_ARITH: shift_op = wsd_pkg::WSD_OP_SHIFT_RIGHT_ARITH; // RULE17
      `WSD_SH_ROT:
      begin
        // zero amount means a single bit through carry, not a no-op rotate
        if (shift_amt == `WSD_AMT_ZERO)
          shift_op = wsd_pkg::WSD_OP_ROTATE_EXTEND; // RULE18
        else
          shift_op = wsd_pkg::WSD_OP_ROTATE_RIGHT; // RULE18
      end
    endcase
  end
endmodule : wsd_shift_dec
`default_nettype wire

// file: logic/wsd_decoder.sv
// combinational decoder for wide stores, shifted-register alu ops and moves/shifts
// Function
// RULE1: store selectors 100 or 000/1xxxxx give byte store immediate; 000/0xxxxx register form.
// RULE2: selectors 101 or 001/1xxxxx give halfword store immediate; 001/0xxxxx register form.
// RULE3: selectors 110 or 010/1xxxxx give word store immediate; 010/0xxxxx register form.
// RULE4: any other store-space encoding is undefined.
// RULE5: function 0000 is and; destination 1111 gives bit test or unpredictable.
// RULE6: function 0001 is bit clear for all other fields.
// RULE7: function 0010 is or, or the move/shift group when first operand is 1111.
// RULE8: function 0011 is or-not, or bitwise not when first operand is 1111.
// RULE9: function 0100 is exclusive or; destination 1111 gives equivalence test or unpredictable.
// RULE10: function 1000 is add; destination 1111 gives compare negative or unpredictable.
// RULE11: function 1010 is add with carry, 1011 subtract with carry.
// RULE12: function 1101 is subtract; destination 1111 gives compare or unpredictable.
// RULE13: function 1110 is reverse subtract for all other fields.
// RULE14: other shifted-register functions are undefined.
// RULE15: shift type 00 with zero amount is move, else left logical shift.
// RULE16: shift type 01 is right logical shift by immediate.
// RULE17: shift type 10 is right arithmetic shift by immediate.
// RULE18: shift type 11 with zero amount is rotate extend, else rotate right.
// RULE19: amount is bits 14:12 joined to bits 7:6; type is bits 5:4.
// RULE20: purely combinational; one operation plus undefined and unpredictable flags.
`timescale 1ns/10ps
`default_nettype none
`include "wsd_cfg.svh"
module wsd_decoder (
  // clock and reset, unused by the combinational path
  input wire logic sys_clk,
  input wire logic rst,
  // instruction halfwords from fetch
  input wire logic [15:0] hw1,
  input wire logic [15:0] hw2,
  // decode result to execute
  output var wsd_pkg::wsd_op_t op,
  output logic [4:0] shift_amt,
  output logic is_undefined,
  output logic is_unpredictable,
  output logic is_claimed
);
  logic [2:0] store_size_sel;
  logic [5:0] store_form_sel;
  logic [3:0] alu_function;
  logic [3:0] first_operand_reg;
  logic [3:0] dest_reg;
  logic set_flags;
  logic in_store;
  logic in_dp;
  logic dest_pc;
  logic first_pc;
  wsd_pkg::wsd_op_t shift_op;

  // a destination of 1111 selects a flag-only form, or nothing if flags are off
  function automatic wsd_pkg::wsd_op_t pick_flag_form(
    input logic dpc,
    input logic s,
    input wsd_pkg::wsd_op_t normal,
    input wsd_pkg::wsd_op_t flag_only
  );
    if (!dpc)
      return normal;
    else if (s)
      return flag_only;
    else
      return wsd_pkg::WSD_OP_NONE;
  endfunction : pick_flag_form

  wsd_shift_dec wsd_shift_dec_i (
    .hw2(hw2),
    .shift_op(shift_op),
    .shift_amt(shift_amt)
  );

  assign store_size_sel = hw1[7:5];
  assign store_form_sel = hw2[11:6];
  assign alu_function = hw1[8:5];
  assign first_operand_reg = hw1[3:0];
  assign dest_reg = hw2[11:8];
  assign set_flags = hw1[4];
  assign in_store = ({hw1[15:8], hw1[4]} == `WSD_STORE_MATCH);
  assign in_dp = (hw1[15:9] == `WSD_DP_MATCH);
  assign dest_pc = (dest_reg == `WSD_REG_PC);
  assign first_pc = (first_operand_reg == `WSD_REG_PC);
  // clock and reset are kept for pipeline integration and the bound checker
  assign is_claimed = in_store | in_dp;

  // no state here: the execute stage registers the result if it needs to
  always_comb
  begin // RULE20
    op = wsd_pkg::WSD_OP_NONE;
    is_undefined = 1'b0;
    is_unpredictable = 1'b0;
    if (in_store)
    begin
      unique case (store_size_sel)
        `WSD_SEL_BYTE_IMM: op = wsd_pkg::WSD_OP_BYTE_STORE_IMM; // RULE1
        `WSD_SEL_HALF_IMM: op = wsd_pkg::WSD_OP_HALFWORD_STORE_IMM; // RULE2
        `WSD_SEL_WORD_IMM: op = wsd_pkg::WSD_OP_WORD_STORE_IMM; // RULE3
        `WSD_SEL_BYTE: op = store_form_sel[5] ? wsd_pkg::WSD_OP_BYTE_STORE_IMM
                                              : wsd_pkg::WSD_OP_BYTE_STORE_REG; // RULE1
        `WSD_SEL_HALF: op = store_form_sel[5] ? wsd_pkg::WSD_OP_HALFWORD_STORE_IMM
                                              : wsd_pkg::WSD_OP_HALFWORD_STORE_REG; // RULE2
        `WSD_SEL_WORD: op = store_form_sel[5] ? wsd_pkg::WSD_OP_WORD_STORE_IMM
                                              : wsd_pkg::WSD_OP_WORD_STORE_REG; // RULE3
        default: is_undefined = 1'b1; // RULE4
      endcase
    end
    else if (in_dp)
    begin
      unique case (alu_function)
        `WSD_FN_AND:
        begin
          op = pick_flag_form(dest_pc, set_flags, wsd_pkg::WSD_OP_AND,
                              wsd_pkg::WSD_OP_TEST_BITS); // RULE5
          is_unpredictable = dest_pc & ~set_flags; // RULE5
        end
        `WSD_FN_BITCLR: op = wsd_pkg::WSD_OP_BIT_CLEAR; // RULE6
        `WSD_FN_OR: op = first_pc ? shift_op : wsd_pkg::WSD_OP_BITWISE_OR; // RULE7
        `WSD_FN_ORNOT: op = first_pc ? wsd_pkg::WSD_OP_BITWISE_NOT
                                   : wsd_pkg::WSD_OP_OR_NOT; // RULE8
        `WSD_FN_XOR:
        begin
          op = pick_flag_form(dest_pc, set_flags, wsd_pkg::WSD_OP_EXCLUSIVE_OR,
                              wsd_pkg::WSD_OP_TEST_EQUIVALENCE); // RULE9
          is_unpredictable = dest_pc & ~set_flags; // RULE9
        end
        `WSD_FN_ADD:
        begin
          op = pick_flag_form(dest_pc, set_flags, wsd_pkg::WSD_OP_ADD,
                              wsd_pkg::WSD_OP_COMPARE_NEGATIVE); // RULE10
          is_unpredictable = dest_pc & ~set_flags; // RULE10
        end
        `WSD_FN_ADC: op = wsd_pkg::WSD_OP_ADD_WITH_CARRY; // RULE11
        `WSD_FN_SUBC: op = wsd_pkg::WSD_OP_SUBTRACT_WITH_BORROW; // RULE11
        `WSD_FN_SUB:
        begin
          op = pick_flag_form(dest_pc, set_flags, wsd_pkg::WSD_OP_SUBTRACT,
                              wsd_pkg::WSD_OP_COMPARE); // RULE12
          is_unpredictable = dest_pc & ~set_flags; // RULE12
        end
        `WSD_FN_RSUB: op = wsd_pkg::WSD_OP_REVERSE_SUBTRACT; // RULE13
        default: is_undefined = 1'b1; // RULE14
      endcase
    end
  end
endmodule : wsd_decoder
`default_nettype wire

// file: dv/wsd_fetch_model.sv
// fetch stage model handing one wide instruction to the decoder per cycle
`timescale 1ns/10ps
`default_nettype none
module wsd_fetch_model (
  // clock
  input wire logic sys_clk,
  // next wide instruction from the bench
  input wire logic [31:0] next_insn,
  // halfwords to the decoder
  output logic [15:0] hw1,
  output logic [15:0] hw2
);
  // upper half is fetched first, so it is hw1
  always_ff @(posedge sys_clk)
  begin
    {hw1, hw2} <= next_insn;
  end
endmodule : wsd_fetch_model
`default_nettype wire

// file: dv/wsd_decoder_checker.sv
// assertions on the decoder ports
`timescale 1ns/10ps
`default_nettype none
module wsd_decoder_checker (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // instruction and result
  input wire logic [15:0] hw1,
  input wire logic [15:0] hw2,
  input var wsd_pkg::wsd_op_t op,
  input wire logic [4:0] shift_amt,
  input wire logic is_undefined,
  input wire logic is_unpredictable,
  input wire logic is_claimed
);
  logic st, dp, mv, rd15;
  logic [3:0] fn;
  assign st = hw1[15:8] == 8'hf8 && !hw1[4];
  assign dp = hw1[15:9] == 7'h75;
  assign fn = hw1[8:5];
  assign mv = dp && fn == 4'h2 && hw1[3:0] == 4'hf;
  assign rd15 = hw2[11:8] == 4'hf;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_byte_reg: assert property (st && hw1[7:5] == 3'h0 && !hw2[11] |->
    op == wsd_pkg::WSD_OP_BYTE_STORE_REG) else $error("byte store form wrong");
  a_store_undef: assert property (st && hw1[6:5] == 2'h3 |-> is_undefined)
    else $error("store size not refused");
  a_test_unpred: assert property (dp && fn inside {4'h0, 4'h4, 4'h8, 4'hd} && rd15
    && !hw1[4] |-> is_unpredictable && !is_undefined) else $error("unpredictable missed");
  a_sub_compare: assert property (dp && fn == 4'hd && rd15 && hw1[4] |->
    op == wsd_pkg::WSD_OP_COMPARE) else $error("compare form missed");
  a_not_form: assert property (dp && fn == 4'h3 && hw1[3:0] == 4'hf |->
    op == wsd_pkg::WSD_OP_BITWISE_NOT) else $error("bitwise not missed");
  a_dp_undef: assert property (dp && fn inside {4'h5, 4'h6, 4'h7, 4'h9, 4'hc, 4'hf}
    |-> is_undefined && op == wsd_pkg::WSD_OP_NONE) else $error("alu function not refused");
  a_amt_join: assert property (shift_amt == {hw2[14:12], hw2[7:6]})
    else $error("shift amount wrong");
  a_left_shift: assert property (mv && hw2[5:4] == 2'h0 && hw2[7:6] != 2'h0 |->
    op == wsd_pkg::WSD_OP_SHIFT_LEFT_LOGICAL) else $error("left shift missed");
  a_rotate_ext: assert property (mv && hw2[5:4] == 2'h3 && shift_amt == 5'h00 |->
    op == wsd_pkg::WSD_OP_ROTATE_EXTEND) else $error("rotate extend missed");
  a_op_stable: assert property ($stable(hw1) && $stable(hw2) |-> $stable(op))
    else $error("op moved with steady inputs");
  a_claim_space: assert property (is_claimed == (st || dp))
    else $error("claim wrong");
endmodule : wsd_decoder_checker
bind wsd_decoder wsd_decoder_checker wsd_decoder_checker_i (.sys_clk(sys_clk), .rst(rst),
  .hw1(hw1), .hw2(hw2), .op(op), .shift_amt(shift_amt), .is_undefined(is_undefined),
  .is_unpredictable(is_unpredictable), .is_claimed(is_claimed));
`default_nettype wire

// file: dv/tb_wsd_decoder.sv
// self-checking bench for the wide store / alu / shift decoder
`timescale 1ns/10ps
`default_nettype none
module tb_wsd_decoder;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [31:0] next_insn = 32'h0000_0000;
  logic [15:0] hw1, hw2;
  wsd_pkg::wsd_op_t op;
  logic [4:0] shift_amt;
  logic is_undefined, is_unpredictable, is_claimed;
  int num_errors = 0;
  int compares = 0;
  // alu op codes per function, 00 where the function is unallocated
  logic [4:0] nrm [16] = '{5'h07, 5'h09, 5'h0a, 5'h0b, 5'h0d, 5'h00, 5'h00, 5'h00,
    5'h0f, 5'h00, 5'h11, 5'h12, 5'h00, 5'h13, 5'h15, 5'h00};
  initial forever #2.5 sys_clk = ~sys_clk;
  wsd_fetch_model wsd_fetch_model_i (.sys_clk(sys_clk), .next_insn(next_insn), .hw1(hw1),
    .hw2(hw2));
  wsd_decoder wsd_decoder_i (.sys_clk(sys_clk), .rst(rst), .hw1(hw1), .hw2(hw2), .op(op),
    .shift_amt(shift_amt), .is_undefined(is_undefined), .is_unpredictable(is_unpredictable),
    .is_claimed(is_claimed));
  // flags are {undefined, unpredictable, claimed}; one cycle through the fetch model
  task automatic chk(input logic [31:0] insn, input logic [4:0] e_op, input logic [2:0] fl);
    @(posedge sys_clk);
    next_insn <= insn;
    @(posedge sys_clk);
    #1;
    compares++;
    if ({op, is_undefined, is_unpredictable, is_claimed} !== {e_op, fl})
      $display("Error %h op+flags exp %h seen %h", insn, {e_op, fl},
        {op, is_undefined, is_unpredictable, is_claimed});
    if ({op, is_undefined, is_unpredictable, is_claimed} !== {e_op, fl})
      num_errors++;
  endtask : chk
  task automatic t_store;
    logic [4:0] e;
    for (int s = 0; s < 16; s++)
    begin
      e = 5'h01 + {2'h0, s[2:1], 1'b0} + {4'h0, !(s[3] | s[0])};
      if (s[2:1] == 2'h3)
        e = 5'h00;
      chk({8'hf8, s[3:1], 5'h03, 4'h5, s[0], 11'h000}, e, {s[2:1] == 2'h3, 2'h1});
    end
  endtask : t_store
  task automatic t_alu;
    logic [3:0] fn;
    logic rd, s, rn;
    logic [4:0] e;
    logic [2:0] fl;
    for (int i = 0; i < 128; i++)
    begin
      {fn, rd, s, rn} = i[6:0];
      e = nrm[fn];
      fl = (e == 5'h00) ? 3'h5 : 3'h1;
      // subtract shares the flag-only form with and, exclusive or and add
      if (rd && !s && (fn inside {4'h0, 4'h4, 4'h8, 4'hd}))
        {e, fl} = {5'h00, 3'h3};
      else if (rd && (fn inside {4'h0, 4'h4, 4'h8, 4'hd}))
        e = e + 5'h01;
      else if (rn && fn == 4'h2)
        e = 5'h16;
      else if (rn && fn == 4'h3)
        e = 5'h0c;
      chk({7'h75, fn, s, {4{rn}}, 4'h0, {4{rd}}, 8'h00}, e, fl);
    end
  endtask : t_alu
  task automatic t_shift;
    logic [4:0] amt;
    logic [1:0] t;
    for (int i = 0; i < 12; i++)
    begin
      t = i[1:0];
      amt = (i < 4) ? 5'h00 : (i < 8) ? 5'h01 : 5'h14;
      chk({16'hea4f, 1'b0, amt[4:2], 4'h3, amt[1:0], t, 4'h7}, 5'h16 + {3'h0, t} +
        {4'h0, t != 2'h0} + {4'h0, amt != 5'h00 && (t == 2'h0 || t == 2'h3)}, 3'h1);
      compares++;
      if (shift_amt !== amt)
        $display("Error shift_amt exp %h seen %h", amt, shift_amt);
      num_errors += (shift_amt !== amt);
    end
  endtask : t_shift
  task automatic results;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  initial
  begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    t_store();
    t_alu();
    t_shift();
    chk(32'h0000_0000, 5'h00, 3'h0);
    chk(32'hf810_0800, 5'h00, 3'h0);
    results();
  end
endmodule : tb_wsd_decoder
`default_nettype wire
